/* File: core/uart_tx_dma_pkg.sv */
package uart_tx_dma_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] DATA_OFFSET   = 8'h00;
  localparam logic [7:0] DMA_SEL_OFFSET = 8'h04;
  localparam logic [7:0] CTRL_OFFSET   = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] BAUD_OFFSET   = 8'h10;

  // Field positions in the DMA select register.
  localparam int TX_DMA_BIT = 7;
  localparam int RX_DMA_BIT = 5;

  // Baud divider width and reset modulus.
  localparam int              BAUD_W     = 13;
  localparam logic [12:0]     BAUD_RESET = 13'h00d9;
  localparam logic [12:0]     BAUD_ONE   = 13'h0001;

  // Frame geometry.
  localparam int          FRAME_W   = 12;
  localparam logic [3:0]  BASE_LEN  = 4'ha;
  localparam logic [3:0]  LEN_ONE   = 4'h1;
  localparam logic [3:0]  LEN_ZERO  = 4'h0;
  localparam logic [3:0]  RX_LAST8  = 4'h9;

  // Transfer type code for a non-sequential transfer.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Software controls, held in the control register at bits 9..0.
  typedef struct packed {
    logic tx_complete_irq_enable;
    logic rx_full_irq_enable;
    logic tx_empty_irq_enable;
    logic receiver_enable;
    logic transmitter_enable;
    logic send_break;
    logic stop_bit_count_select;
    logic nine_bit;
    logic tx_ninth_bit;
    logic output_invert;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = 10'h000;

  // Request type selection for the two buffer flags.
  typedef struct packed {
    logic tx_dma_select;
    logic rx_dma_select;
  } dma_sel_type;

  // Status flags, read at bits 4..0 of the status register.
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_complete_flag;
    logic rx_buffer_full_flag;
    logic overrun_flag;
    logic rx_ninth_bit;
  } status_type;

  localparam status_type STATUS_RESET = 5'h18;

  // Request lines toward the interrupt and DMA controllers.
  typedef struct packed {
    logic tx_irq;
    logic tx_dma;
    logic rx_irq;
    logic rx_dma;
    logic tc_irq;
  } request_type;

  typedef enum logic {RX_IDLE, RX_BUSY} rx_state_type;

endpackage : uart_tx_dma_pkg

/* File: core/uart_tx_dma.sv */
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - One data address: reads give receive buffer, writes load transmit buffer.
// - Data register accesses complete the automatic status flag clearing sequences.
// - DMA select bit 7 steers the transmit-empty request to interrupt or DMA.
// - Without the transmit-empty enable, neither transmit-empty request is raised.
// - DMA select bit 5 steers the receive-full request to interrupt or DMA.
// - Without the receive-full enable, neither receive-full request is raised.
// - DMA select bits 6, 4, 3 and 2..0 are read-only zero.
// - Transmitter and receiver run independently but share one baud divider.
// - The baud generator is clocked from the bus clock.
// - Receive bit timing restarts on every falling edge of the line.
// - Output idles high after reset; the invert control flips the output.
// - Enabling the transmitter queues one idle-level preamble frame.
// - After the preamble the transmitter waits for a written character.
// - The shift frame is 10, 11 or 12 bits by nine-bit and stop-bit selects.
// - Eight-bit frames are one start, eight data and one or two stop bits.
// - A free shifter takes the buffer on a baud tick, then sets transmit-empty.
// - With no data after a stop bit, set complete and idle high.
// - Clearing enable keeps the pin driven until queued frames finish.
// - Low start bit, data least significant first, one or two high stop bits.
// - Inversion applies to every transmitted level, idle and break included.
// - In nine-bit mode the stored ninth bit joins the written byte.
module uart_tx_dma (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic                          hready,
  input  wire logic [31:0]                   hwdata,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          rxd,
  output logic                               txd,
  output logic                               txd_oen,
  output var uart_tx_dma_pkg::request_type   requests
);

  uart_tx_dma_pkg::ctrl_type     ctrl;
  uart_tx_dma_pkg::ctrl_type     ctrl_wr;
  uart_tx_dma_pkg::dma_sel_type  dma_sel;
  uart_tx_dma_pkg::status_type   status;
  uart_tx_dma_pkg::rx_state_type rx_state;
  logic [12:0]  baud_div;
  logic [12:0]  baud_cnt;
  logic         baud_tick;
  logic         wr_pend;
  logic [7:0]   wr_addr;
  logic         rd_take;
  logic         wr_take;
  logic [7:0]   acc_addr;
  logic         data_wr;
  logic         data_rd;
  logic         arm_tx;
  logic         arm_rx;
  logic [8:0]   tx_buf;
  logic         tx_buf_valid;
  logic [11:0]  shreg;
  logic [3:0]   bits_left;
  logic         preamble_pending;
  logic         break_pending;
  logic         load_any;
  logic         load_data;
  logic         frame_end;
  logic [7:0]   rx_data;
  logic         rxd_meta;
  logic         rxd_sync;
  logic         rxd_last;
  logic         rx_fall;
  logic [12:0]  rx_cnt;
  logic [3:0]   rx_idx;
  logic [8:0]   rx_shift;
  logic         rx_sample;
  logic         rx_wrap;
  logic [12:0]  mod_now;
  logic [3:0]   rx_stop_idx;
  logic         rx_done;

  // A modulus of zero would stall the generator, so it acts as one.
  function automatic logic [12:0] modulus(input logic [12:0] d);
    modulus = (d == 13'h0000) ? uart_tx_dma_pkg::BAUD_ONE : d;
  endfunction : modulus

  // Frame length in bits for the current format.
  function automatic logic [3:0] frame_len(input uart_tx_dma_pkg::ctrl_type c);
    frame_len = uart_tx_dma_pkg::BASE_LEN + {3'h0, c.nine_bit} + {3'h0, c.stop_bit_count_select};
  endfunction : frame_len

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  assign rd_take = hsel && hready && (htrans == uart_tx_dma_pkg::HTRANS_NONSEQ) && !hwrite;
  assign wr_take = hsel && hready && (htrans == uart_tx_dma_pkg::HTRANS_NONSEQ) && hwrite;
  assign acc_addr = haddr[7:0];
  assign data_wr = wr_pend && (wr_addr == uart_tx_dma_pkg::DATA_OFFSET);
  assign data_rd = rd_take && (acc_addr == uart_tx_dma_pkg::DATA_OFFSET);
  assign ctrl_wr = hwdata[9:0];

  // Every access completes with no wait state, so ready and response stay fixed.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= wr_take;
      wr_addr   <= acc_addr;
    end
  end

  // Read data is built in the address phase so it stands from a flop in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      case (acc_addr)
        uart_tx_dma_pkg::DATA_OFFSET:    hrdata <= {24'h000000, rx_data};
        uart_tx_dma_pkg::DMA_SEL_OFFSET: hrdata <= {24'h000000, dma_sel.tx_dma_select, 1'b0,
                                                    dma_sel.rx_dma_select, 5'h00};
        uart_tx_dma_pkg::CTRL_OFFSET:    hrdata <= {22'h000000, ctrl};
        uart_tx_dma_pkg::STATUS_OFFSET:  hrdata <= {27'h0000000, status};
        uart_tx_dma_pkg::BAUD_OFFSET:    hrdata <= {19'h00000, baud_div};
        default:                         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control writes; a rising transmitter enable and a break write queue idle and break frames.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl     <= uart_tx_dma_pkg::CTRL_RESET;
      dma_sel  <= 2'h0;
      baud_div <= uart_tx_dma_pkg::BAUD_RESET;
    end else if (wr_pend) begin
      case (wr_addr)
        uart_tx_dma_pkg::CTRL_OFFSET:    ctrl <= ctrl_wr;
        uart_tx_dma_pkg::DMA_SEL_OFFSET: dma_sel <= {hwdata[uart_tx_dma_pkg::TX_DMA_BIT],
                                                      hwdata[uart_tx_dma_pkg::RX_DMA_BIT]};
        uart_tx_dma_pkg::BAUD_OFFSET:    baud_div <= hwdata[12:0];
        default:                         ctrl <= ctrl;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Baud generator, used by the transmitter and clocked by the bus clock.

  // One tick per bit period; the receiver keeps its own phase against the same modulus.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt  <= 13'h0000;
      baud_tick <= 1'b0;
    end else if (baud_cnt >= modulus(baud_div) - uart_tx_dma_pkg::BAUD_ONE) begin
      baud_cnt  <= 13'h0000;
      baud_tick <= 1'b1;
    end else begin
      baud_cnt  <= baud_cnt + uart_tx_dma_pkg::BAUD_ONE;
      baud_tick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flag clearing sequences.

  // A status read with a flag set arms the sequence; the data access then finishes it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_tx <= 1'b0;
      arm_rx <= 1'b0;
    end else begin
      if (rd_take && acc_addr == uart_tx_dma_pkg::STATUS_OFFSET) begin
        arm_tx <= status.tx_buffer_empty_flag || status.tx_complete_flag;
        arm_rx <= status.rx_buffer_full_flag || status.overrun_flag;
      end else begin
        if (data_wr) arm_tx <= 1'b0;
        if (data_rd) arm_rx <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  assign frame_end = baud_tick && (bits_left == uart_tx_dma_pkg::LEN_ONE);
  assign load_any  = baud_tick && (bits_left <= uart_tx_dma_pkg::LEN_ONE) &&
                     (preamble_pending || break_pending ||
                      (tx_buf_valid && ctrl.transmitter_enable));
  assign load_data = load_any && !preamble_pending && !break_pending;

  // Transmit buffer; a write with DMA selected and the transmit-empty enable set is the DMA service and needs no arming step.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf       <= 9'h000;
      tx_buf_valid <= 1'b0;
    end else if (data_wr) begin
      tx_buf       <= {ctrl.tx_ninth_bit, hwdata[7:0]};
      tx_buf_valid <= 1'b1;
    end else if (load_data) begin
      tx_buf_valid <= 1'b0;
    end
  end

  // Queued idle and break frames take the shifter ahead of buffered data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preamble_pending <= 1'b0;
      break_pending    <= 1'b0;
    end else begin
      if (wr_pend && wr_addr == uart_tx_dma_pkg::CTRL_OFFSET && ctrl_wr.transmitter_enable &&
          !ctrl.transmitter_enable) begin
        preamble_pending <= 1'b1;
      end else if (load_any && preamble_pending) begin
        preamble_pending <= 1'b0;
      end
      if (wr_pend && wr_addr == uart_tx_dma_pkg::CTRL_OFFSET && ctrl_wr.send_break) begin
        break_pending <= 1'b1;
      end else if (load_any && !preamble_pending && break_pending) begin
        break_pending <= ctrl.send_break;
      end
    end
  end

  // Shifter: bit 0 is the line; the frame is start, data lsb first, then stop bits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shreg     <= 12'hfff;
      bits_left <= uart_tx_dma_pkg::LEN_ZERO;
    end else if (load_any) begin
      bits_left <= frame_len(ctrl);
      if (preamble_pending) begin
        shreg <= 12'hfff;
      end else if (break_pending) begin
        shreg <= 12'h000;
      end else if (ctrl.nine_bit) begin
        shreg <= {2'h3, tx_buf, 1'b0};
      end else begin
        shreg <= {3'h7, tx_buf[7:0], 1'b0};
      end
    end else if (frame_end) begin
      bits_left <= uart_tx_dma_pkg::LEN_ZERO;
      shreg     <= 12'hfff;
    end else if (baud_tick && bits_left != uart_tx_dma_pkg::LEN_ZERO) begin
      bits_left <= bits_left - uart_tx_dma_pkg::LEN_ONE;
      shreg     <= {1'b1, shreg[11:1]};
    end
  end

  // Pin drive: idle is high, and the enable holds while anything is queued or shifting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd     <= 1'b1;
      txd_oen <= 1'b1;
    end else begin
      txd     <= ((bits_left == uart_tx_dma_pkg::LEN_ZERO) ? 1'b1 : shreg[0])
                 ^ ctrl.output_invert;
      txd_oen <= !(ctrl.transmitter_enable || bits_left != uart_tx_dma_pkg::LEN_ZERO ||
                   preamble_pending || break_pending);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver, independent of the transmitter apart from the shared modulus.

  assign rx_fall   = rxd_last && !rxd_sync;
  assign mod_now   = modulus(baud_div);
  assign rx_sample = (rx_cnt == {1'b0, mod_now[12:1]});
  assign rx_wrap   = (rx_cnt >= mod_now - uart_tx_dma_pkg::BAUD_ONE);

  // Two-flop synchroniser; only the second stage feeds edge detection.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_last <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
      rxd_last <= rxd_sync;
    end
  end

  // Bit timing: any falling edge realigns the bit phase to zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= uart_tx_dma_pkg::RX_IDLE;
      rx_cnt   <= 13'h0000;
      rx_idx   <= uart_tx_dma_pkg::LEN_ZERO;
      rx_shift <= 9'h000;
    end else begin
      case (rx_state)
        uart_tx_dma_pkg::RX_IDLE: begin
          rx_cnt <= 13'h0000;
          rx_idx <= uart_tx_dma_pkg::LEN_ZERO;
          if (rx_fall && ctrl.receiver_enable) rx_state <= uart_tx_dma_pkg::RX_BUSY;
        end
        uart_tx_dma_pkg::RX_BUSY: begin
          if (rx_fall) begin
            rx_cnt <= 13'h0000;
            // A fall past the sample point opens the next bit, so the index moves on as well.
            if (rx_cnt > {1'b0, mod_now[12:1]}) rx_idx <= rx_idx + uart_tx_dma_pkg::LEN_ONE;
          end else if (rx_wrap) begin
            rx_cnt <= 13'h0000;
            rx_idx <= rx_idx + uart_tx_dma_pkg::LEN_ONE;
          end else begin
            rx_cnt <= rx_cnt + uart_tx_dma_pkg::BAUD_ONE;
          end
          if (rx_sample && !rx_fall) begin
            if (rx_idx == uart_tx_dma_pkg::LEN_ZERO && rxd_sync) begin
              rx_state <= uart_tx_dma_pkg::RX_IDLE;
            end else if (rx_idx == rx_stop_idx) begin
              rx_state <= uart_tx_dma_pkg::RX_IDLE;
            end else if (rx_idx != uart_tx_dma_pkg::LEN_ZERO) begin
              rx_shift <= ctrl.nine_bit ? {rxd_sync, rx_shift[8:1]} :
                                          {1'b0, rxd_sync, rx_shift[7:1]};
            end
          end
        end
        default: rx_state <= uart_tx_dma_pkg::RX_IDLE;
      endcase
    end
  end

  // The stop bit is sampled at this index, so the character is complete there.
  assign rx_stop_idx = uart_tx_dma_pkg::RX_LAST8 + {3'h0, ctrl.nine_bit};
  assign rx_done     = (rx_state == uart_tx_dma_pkg::RX_BUSY) && rx_sample && !rx_fall &&
                       (rx_idx == rx_stop_idx);

  //////////////////////////////////////////////////////////////////////////////
  // Status flags. Hardware sets win over a clear in the same cycle.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status  <= uart_tx_dma_pkg::STATUS_RESET;
      rx_data <= 8'h00;
    end else begin
      if (load_data) status.tx_buffer_empty_flag <= 1'b1;
      else if (data_wr && (arm_tx || (dma_sel.tx_dma_select && ctrl.tx_empty_irq_enable)))
        status.tx_buffer_empty_flag <= 1'b0;
      if (frame_end && !load_any) status.tx_complete_flag <= 1'b1;
      else if (data_wr && arm_tx) status.tx_complete_flag <= 1'b0;
      else if (load_any) status.tx_complete_flag <= 1'b0;
      if (rx_done && !status.rx_buffer_full_flag) begin
        rx_data                     <= rx_shift[7:0];
        status.rx_ninth_bit         <= ctrl.nine_bit & rx_shift[8];
        status.rx_buffer_full_flag  <= 1'b1;
      end else if (data_rd && (arm_rx || (dma_sel.rx_dma_select && ctrl.rx_full_irq_enable))) begin
        status.rx_buffer_full_flag  <= 1'b0;
      end
      if (rx_done && status.rx_buffer_full_flag) status.overrun_flag <= 1'b1;
      else if (data_rd && arm_rx) status.overrun_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request outputs; a cleared enable silences both the interrupt and the DMA line.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      requests <= 5'h00;
    end else begin
      requests.tx_irq <= ctrl.tx_empty_irq_enable && status.tx_buffer_empty_flag &&
                         !dma_sel.tx_dma_select;
      requests.tx_dma <= ctrl.tx_empty_irq_enable && status.tx_buffer_empty_flag &&
                         dma_sel.tx_dma_select;
      requests.rx_irq <= ctrl.rx_full_irq_enable && status.rx_buffer_full_flag &&
                         !dma_sel.rx_dma_select;
      requests.rx_dma <= ctrl.rx_full_irq_enable && status.rx_buffer_full_flag &&
                         dma_sel.rx_dma_select;
      requests.tc_irq <= ctrl.tx_complete_irq_enable && status.tx_complete_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  reserved_zero_a: assert property (rd_take && acc_addr == uart_tx_dma_pkg::DMA_SEL_OFFSET |=> (hrdata[6] == 1'b0 && hrdata[4:0] == 5'h00 && hrdata[31:8] == 24'h000000)) else $error("reserved select bits not zero");
  tx_select_a: assert property (ctrl.tx_empty_irq_enable && status.tx_buffer_empty_flag |=> requests.tx_dma == $past(dma_sel.tx_dma_select) && requests.tx_irq != $past(dma_sel.tx_dma_select)) else $error("tx request type wrong");
  tx_gate_a: assert property (!ctrl.tx_empty_irq_enable |=> !requests.tx_dma && !requests.tx_irq) else $error("tx request without enable");
  rx_select_a: assert property (ctrl.rx_full_irq_enable && status.rx_buffer_full_flag |=> requests.rx_dma == $past(dma_sel.rx_dma_select)) else $error("rx request type wrong");
  rx_gate_a: assert property (!ctrl.rx_full_irq_enable |=> !requests.rx_dma && !requests.rx_irq) else $error("rx request without enable");
  idle_level_a: assert property (bits_left == uart_tx_dma_pkg::LEN_ZERO |=> txd == !$past(ctrl.output_invert)) else $error("idle level wrong");
  start_bit_a: assert property (load_data && !ctrl.output_invert ##1 !ctrl.output_invert |=> txd == 1'b0) else $error("start bit not low");
  empty_set_a: assert property (load_data |=> status.tx_buffer_empty_flag && !tx_buf_valid || $past(data_wr)) else $error("empty flag not set on load");
  frame_len_a: assert property (load_any |=> bits_left >= 4'ha && bits_left <= 4'hc) else $error("frame length out of range");
  pin_hold_a: assert property (bits_left != uart_tx_dma_pkg::LEN_ZERO |=> !txd_oen) else $error("pin released mid frame");
  wait_data_a: assert property (bits_left == uart_tx_dma_pkg::LEN_ZERO && !tx_buf_valid && !preamble_pending && !break_pending |=> bits_left == uart_tx_dma_pkg::LEN_ZERO) else $error("shifter started without data");

  preamble_c: cover property (load_any && preamble_pending);
  data_frame_c: cover property (load_data ##[1:300] frame_end);
  dma_req_c: cover property (requests.tx_dma);
  rx_done_c: cover property (rx_done);

endmodule : uart_tx_dma

`default_nettype wire

/* File: verification/uart_remote_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Far-side serial port: decodes frames on txd and can send frames on rxd.
module uart_remote_model #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] last_byte;
  int         frames;

  initial rxd = 1'b1;
  initial frames = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Each bit is sampled at its middle, so small phase errors do not matter.
  always begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT_CLKS) @(posedge clk);
      last_byte[k] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk);
    frames++;
  end

  // One frame: low start bit, data lsb first, high stop bit, then idle high.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      rxd <= f[k];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask : send
endmodule : uart_remote_model

`default_nettype wire

/* File: verification/test_uart_transmit_and_dma_select.sv */
`timescale 1ns/10ps
`default_nettype none

module test_uart_transmit_and_dma_select;
  logic                         hclk, hresetn, hsel, hwrite, hready, rxd, txd, txd_oen;
  logic                         hreadyout, hresp;
  logic [31:0]                  haddr, hwdata, hrdata, rd;
  logic [1:0]                   htrans;
  logic [2:0]                   hsize;
  logic [7:0]                   b;
  logic [7:0]                   pat [4];
  uart_tx_dma_pkg::request_type requests;
  int                           errors, samples_checked, cycles, seed, n, f0;

  assign hready = hreadyout;

  uart_tx_dma dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
    .txd_oen(txd_oen), .requests(requests));
  uart_remote_model #(.BIT_CLKS(4)) partner (.clk(hclk), .txd(txd), .rxd(rxd));

  always #20 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: address phase held until hready, then data phase likewise.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= uart_tx_dma_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Transmit-empty request expected for a given enable and select.
  function automatic logic [4:0] exp_tx(input logic en, input logic dma);
    return en ? (dma ? 5'h08 : 5'h10) : 5'h00;
  endfunction : exp_tx

  // Bounded wait for the partner to finish a frame, then compare its byte.
  task automatic frame_check(input logic [7:0] exp);
    n = 0;
    while (partner.frames == f0 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    f0 = partner.frames;
    check(n < 400, 32'h1);
    check(partner.last_byte, exp);
  endtask : frame_check

  task automatic stop_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Hang guard, far above the few hundred cycles the tests need.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; errors = 0; samples_checked = 0; cycles = 0;
    seed = 18242;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(txd, 32'h1);
    bus(1'b0, uart_tx_dma_pkg::STATUS_OFFSET, 32'h0);
    check(rd, 32'h18);
    bus(1'b1, uart_tx_dma_pkg::DMA_SEL_OFFSET, 32'hff);
    bus(1'b0, uart_tx_dma_pkg::DMA_SEL_OFFSET, 32'h0);
    check(rd, 32'ha0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, uart_tx_dma_pkg::CTRL_OFFSET, i[0] ? 32'h80 : 32'h0);
      bus(1'b1, uart_tx_dma_pkg::DMA_SEL_OFFSET, i[1] ? 32'h80 : 32'h0);
      repeat (2) @(posedge hclk);
      check(requests, exp_tx(i[0], i[1]));
    end
    $display("register test done");
    pat[0] = 8'h00;
    pat[1] = 8'hff;
    pat[2] = 8'($random(seed));
    pat[3] = 8'($random(seed));
    bus(1'b1, uart_tx_dma_pkg::BAUD_OFFSET, 32'h4);
    f0 = partner.frames;
    bus(1'b1, uart_tx_dma_pkg::CTRL_OFFSET, 32'h20);
    bus(1'b1, uart_tx_dma_pkg::DATA_OFFSET, {24'h0, pat[0]});
    n = 0;
    while (txd !== 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    check(n >= 36 && n < 200, 32'h1);
    check(txd_oen, 32'h0);
    frame_check(pat[0]);
    for (int k = 1; k < 4; k++) begin
      bus(1'b1, uart_tx_dma_pkg::DATA_OFFSET, {24'h0, pat[k]});
      // Turning the transmitter off mid-frame must not cut the frame short.
      // A buffered character is not yet in progress, so wait for its start bit first.
      if (k == 3) begin
        n = 0;
        while (txd !== 1'b0 && n < 100) begin
          @(posedge hclk);
          n++;
        end
        bus(1'b1, uart_tx_dma_pkg::CTRL_OFFSET, 32'h0);
        check(txd_oen, 32'h0);
      end
      frame_check(pat[k]);
    end
    repeat (12) @(posedge hclk);
    bus(1'b0, uart_tx_dma_pkg::STATUS_OFFSET, 32'h0);
    check(rd & 32'h18, 32'h18);
    check(txd, 32'h1);
    check(txd_oen, 32'h1);
    // A break queued behind the preamble reaches the partner as an all-zero character.
    bus(1'b1, uart_tx_dma_pkg::CTRL_OFFSET, 32'h30);
    bus(1'b1, uart_tx_dma_pkg::CTRL_OFFSET, 32'h20);
    frame_check(8'h00);
    $display("transmit test done");
    b = 8'($random(seed));
    bus(1'b1, uart_tx_dma_pkg::CTRL_OFFSET, 32'h140);
    bus(1'b1, uart_tx_dma_pkg::DMA_SEL_OFFSET, 32'h20);
    partner.send(b);
    repeat (8) @(posedge hclk);
    check(requests, 32'h02);
    bus(1'b1, uart_tx_dma_pkg::DMA_SEL_OFFSET, 32'h0);
    repeat (2) @(posedge hclk);
    check(requests, 32'h04);
    bus(1'b1, uart_tx_dma_pkg::CTRL_OFFSET, 32'h40);
    repeat (2) @(posedge hclk);
    check(requests, 32'h00);
    bus(1'b0, uart_tx_dma_pkg::STATUS_OFFSET, 32'h0);
    check(rd[2], 32'h1);
    bus(1'b0, uart_tx_dma_pkg::DATA_OFFSET, 32'h0);
    check(rd[7:0], b);
    bus(1'b0, uart_tx_dma_pkg::STATUS_OFFSET, 32'h0);
    check(rd[2], 32'h0);
    $display("receive test done");
    bus(1'b1, uart_tx_dma_pkg::CTRL_OFFSET, 32'h01);
    repeat (3) @(posedge hclk);
    check(txd, 32'h0);
    $display("invert test done");
    stop_test();
  end
endmodule : test_uart_transmit_and_dma_select

`default_nettype wire
